// >>> core/lfbd_fetch.sv
// Frame-buffer fetch engine: AHB-Lite register slave, burst read master, display FIFO, pixel unpacker.
// Assumes memory answers a taken burst request with exactly the requested number of read beats.
`timescale 1ns/1ps

module lfbd_fetch #(
  parameter int FIFO_DEPTH = 32
) (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite register slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Memory read port.
  output lfbd_pkg::lfbd_mreq_s mem_req,
  input wire logic mem_ack,
  input wire lfbd_pkg::lfbd_mresp_s mem_rsp,
  // Display pixel stream and interrupt.
  input wire logic pix_req,
  output lfbd_pkg::lfbd_pix_s pix_out,
  output logic irq
);

  localparam int CW = $clog2(FIFO_DEPTH + 1);
  localparam int PW = $clog2(FIFO_DEPTH);

  // ************************************************************
  // Module state
  // ************************************************************
  typedef struct packed {
    logic [FIFO_DEPTH-1:0][31:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [CW-1:0] cnt;
    logic [47:0] acc;
    logic [2:0] nb;
    lfbd_pkg::lfbd_fetch_e st;
    logic [31:0] addr;
    logic [lfbd_pkg::FRAME_WORDS_W-1:0] left;
    logic [4:0] beats;
    logic power;
    logic dma_en;
    logic dma_en_q;
    logic packed_mode;
    logic [lfbd_pkg::BURST_FIELD_W-1:0] burst_field;
    logic [31:0] base;
    logic [lfbd_pkg::FRAME_WORDS_W-1:0] frame_words;
    logic [lfbd_pkg::IRQ_W-1:0] irq_st;
    logic [lfbd_pkg::IRQ_W-1:0] irq_en;
    logic wr_pend;
    logic [7:0] wr_ofs;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    lfbd_pkg::lfbd_mreq_s mreq;
    lfbd_pkg::lfbd_pix_s pix;
    logic irq;
  } lfbd_state_s;

  lfbd_state_s s_ff;
  lfbd_state_s nxt_s;

  // Scratch values of the combinational process.
  logic addr_phase;
  logic take;
  logic pop;
  logic push;
  logic reload;
  logic [47:0] acc1;
  logic [2:0] nb1;
  logic [8:0] to_kbyte;
  logic [4:0] blen;
  logic [4:0] blen_eff;
  logic [lfbd_pkg::IRQ_W-1:0] ev;
  logic [lfbd_pkg::IRQ_W-1:0] clr;
  logic [31:0] rd_val;

  // ************************************************************
  // Next-state logic
  // ************************************************************
  // One process computes bus, fetch, FIFO and unpacker updates so every flop sees a single driver.
  always_comb begin
    nxt_s = s_ff;
    ev = '0;
    clr = '0;
    reload = 1'b0;
    rd_val = 32'h0000_0000;
    addr_phase = hsel & htrans[1] & hready;

    // ************************************************************
    // Register slave
    // ************************************************************
    // Register writes land in the data phase using the latched offset.
    if (s_ff.wr_pend) begin
      unique case (s_ff.wr_ofs)
        lfbd_pkg::OFS_CTRL: begin
          nxt_s.power = hwdata[lfbd_pkg::CTRL_POWER_BIT];
          nxt_s.dma_en = hwdata[lfbd_pkg::CTRL_DMA_EN_BIT];
          nxt_s.packed_mode = hwdata[lfbd_pkg::CTRL_PACKED_BIT];
          reload = hwdata[lfbd_pkg::CTRL_DMA_RESET_BIT];
        end
        lfbd_pkg::OFS_FRAME_CONFIG: nxt_s.burst_field = hwdata[lfbd_pkg::BURST_FIELD_W-1:0];
        lfbd_pkg::OFS_FRAME_BASE: nxt_s.base = hwdata;
        lfbd_pkg::OFS_FRAME_WORDS: nxt_s.frame_words = hwdata[lfbd_pkg::FRAME_WORDS_W-1:0];
        lfbd_pkg::OFS_IRQ_CLEAR: clr = hwdata[lfbd_pkg::IRQ_W-1:0];
        lfbd_pkg::OFS_IRQ_ENABLE: nxt_s.irq_en = hwdata[lfbd_pkg::IRQ_W-1:0];
        default: ;
      endcase
    end
    nxt_s.wr_pend = addr_phase & hwrite;
    nxt_s.wr_ofs = {haddr[7:2], 2'b00};

    // Read data is sampled in the address phase; unmapped offsets read as zero.
    // The clear register reads as zero because clearing is a write-only action.
    unique case ({haddr[7:2], 2'b00})
      lfbd_pkg::OFS_CTRL: rd_val = {28'h000_0000, s_ff.packed_mode, 1'b0, s_ff.dma_en, s_ff.power};
      lfbd_pkg::OFS_FRAME_CONFIG: rd_val = {28'h000_0000, s_ff.burst_field};
      lfbd_pkg::OFS_FRAME_BASE: rd_val = s_ff.base;
      lfbd_pkg::OFS_FRAME_WORDS: rd_val = {8'h00, s_ff.frame_words};
      lfbd_pkg::OFS_STATUS: rd_val = {8'h00, 8'(s_ff.cnt), 15'h0000, (s_ff.st != lfbd_pkg::FETCH_IDLE)};
      lfbd_pkg::OFS_IRQ_STATUS: rd_val = {29'h0000_0000, s_ff.irq_st};
      lfbd_pkg::OFS_IRQ_ENABLE: rd_val = {29'h0000_0000, s_ff.irq_en};
      default: rd_val = 32'h0000_0000;
    endcase
    nxt_s.hrdata = (addr_phase & ~hwrite) ? rd_val : s_ff.hrdata;
    nxt_s.hreadyout = 1'b1;
    // Every transfer is answered OKAY with no wait state, as the slave has no error case.
    nxt_s.hresp = 1'b0;

    // ************************************************************
    // Enable edge and burst sizing
    // ************************************************************
    // reload on enable
    nxt_s.dma_en_q = s_ff.dma_en;
    if (s_ff.dma_en & ~s_ff.dma_en_q) begin
      reload = 1'b1;
    end

    blen = {1'b0, s_ff.burst_field} + 5'h01;
    // A misaligned base would split a burst across the line; clipping keeps memory safe and raises an event if a full burst of words remains.
    // clip at 1-Kbyte boundary
    to_kbyte = lfbd_pkg::WORDS_PER_KBYTE - {1'b0, s_ff.addr[9:2]};
    if ({4'h0, blen} > to_kbyte) begin
      blen_eff = to_kbyte[4:0];
    end else begin
      blen_eff = blen;
    end
    if ({4'h0, s_ff.left} < 28'(blen_eff)) begin
      blen_eff = s_ff.left[4:0];
    end

    // ************************************************************
    // Fetch sequencer
    // ************************************************************
    // Fetch sequencer: a request waits for FIFO room, so the FIFO never overruns.
    push = 1'b0;
    unique case (s_ff.st)
      lfbd_pkg::FETCH_IDLE: begin
        if (s_ff.dma_en & ~reload) begin
          if (s_ff.left == '0) begin
            ev[lfbd_pkg::IRQ_FRAME_DONE_BIT] = s_ff.frame_words != '0;
            reload = 1'b1;
          end else if (32'(FIFO_DEPTH) - 32'(s_ff.cnt) >= 32'(blen_eff)) begin
            nxt_s.st = lfbd_pkg::FETCH_REQ;
            nxt_s.mreq.req = 1'b1;
            nxt_s.mreq.addr = s_ff.addr;
            nxt_s.mreq.words = blen_eff;
            nxt_s.beats = blen_eff;
            ev[lfbd_pkg::IRQ_BOUNDARY_BIT] = blen_eff < blen && s_ff.left >= 24'(blen);
          end
        end
      end
      // The request stands unchanged until memory accepts it.
      lfbd_pkg::FETCH_REQ: begin
        if (mem_ack) begin
          nxt_s.mreq.req = 1'b0;
          nxt_s.st = lfbd_pkg::FETCH_DATA;
        end
      end
      lfbd_pkg::FETCH_DATA: begin
        if (mem_rsp.valid) begin
          push = 1'b1;
          nxt_s.addr = s_ff.addr + 32'h0000_0004;
          nxt_s.left = s_ff.left - 24'h00_0001;
          nxt_s.beats = s_ff.beats - 5'h01;
          if (s_ff.beats == 5'h01) begin
            nxt_s.st = lfbd_pkg::FETCH_IDLE;
          end
        end
      end
    endcase
    // A reload during a burst would misplace the beats still in flight, so it takes effect only in idle and is dropped otherwise.
    // pointers back to base
    if (reload && (s_ff.st == lfbd_pkg::FETCH_IDLE)) begin
      nxt_s.addr = s_ff.base;
      nxt_s.left = s_ff.frame_words;
    end

    // ************************************************************
    // Pixel unpacker
    // ************************************************************
    // unpack 24-bit pixels
    take = pix_req & s_ff.power & (s_ff.nb >= lfbd_pkg::BYTES_PER_PIXEL);
    ev[lfbd_pkg::IRQ_UNDERFLOW_BIT] = pix_req & s_ff.power & (s_ff.nb < lfbd_pkg::BYTES_PER_PIXEL);
    acc1 = take ? (s_ff.acc >> 24) : s_ff.acc;
    nb1 = take ? (s_ff.nb - lfbd_pkg::BYTES_PER_PIXEL) : s_ff.nb;
    // A word is pulled as soon as fewer than three bytes remain, so a demand seldom finds the buffer short.
    pop = s_ff.power & (s_ff.cnt != '0) & (nb1 < lfbd_pkg::BYTES_PER_PIXEL);
    if (pop) begin
      // Packed words carry four bytes; otherwise only the low three bytes form one pixel.
      if (s_ff.packed_mode) begin
        acc1 = acc1 | 48'({16'h0000, s_ff.mem[s_ff.rp]} << {nb1, 3'b000});
        nb1 = nb1 + lfbd_pkg::BYTES_PACKED_WORD;
      end else begin
        acc1 = acc1 | 48'({24'h00_0000, s_ff.mem[s_ff.rp][23:0]} << {nb1, 3'b000});
        nb1 = nb1 + lfbd_pkg::BYTES_PER_PIXEL;
      end
    end
    nxt_s.acc = acc1;
    nxt_s.nb = nb1;
    nxt_s.pix.valid = take;
    nxt_s.pix.rgb = take ? s_ff.acc[23:0] : s_ff.pix.rgb;

    // ************************************************************
    // Display FIFO
    // ************************************************************
    // FIFO pointers and occupancy.
    if (push) begin
      nxt_s.mem[s_ff.wp] = mem_rsp.data;
      nxt_s.wp = s_ff.wp + PW'(1);
    end
    if (pop) begin
      nxt_s.rp = s_ff.rp + PW'(1);
    end
    nxt_s.cnt = CW'(s_ff.cnt + CW'(push) - CW'(pop));
    // power off clears FIFO
    // Words arriving while power is off are dropped so a restart begins from an empty FIFO.
    if (~s_ff.power) begin
      nxt_s.wp = '0;
      nxt_s.rp = '0;
      nxt_s.cnt = '0;
      nxt_s.acc = '0;
      nxt_s.nb = '0;
    end

    // ************************************************************
    // Interrupts
    // ************************************************************
    // Sticky events: a new event wins over a clear in the same cycle.
    nxt_s.irq_st = (s_ff.irq_st & ~clr) | ev;
    nxt_s.irq = |(nxt_s.irq_st & nxt_s.irq_en);
  end

  // ************************************************************
  // State register
  // ************************************************************
  // Asynchronous reset loads constants only.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_ff <= '0;
      s_ff.st <= lfbd_pkg::FETCH_IDLE;
      s_ff.burst_field <= lfbd_pkg::BURST_FIELD_RST;
      s_ff.base <= lfbd_pkg::FRAME_BASE_RST;
      s_ff.frame_words <= lfbd_pkg::FRAME_WORDS_RST;
      s_ff.hreadyout <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Outputs are taken straight from the state flops.
  assign hreadyout = s_ff.hreadyout;
  assign hresp = s_ff.hresp;
  assign hrdata = s_ff.hrdata;
  assign mem_req = s_ff.mreq;
  assign pix_out = s_ff.pix;
  assign irq = s_ff.irq;

endmodule

// >>> core/lfbd_pkg.sv
// Package of the frame-buffer fetch engine: register map, field layout, reset values, carriers.
// Assumes a single system clock domain shared by the register bus and the memory read port.
package lfbd_pkg;

  // ************************************************************
  // Register map, byte offsets of the AHB-Lite slave
  // ************************************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_FRAME_CONFIG = 8'h04;
  localparam logic [7:0] OFS_FRAME_BASE = 8'h08;
  localparam logic [7:0] OFS_FRAME_WORDS = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h18;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h1c;

  // ************************************************************
  // Field positions and widths
  // ************************************************************
  localparam int CTRL_POWER_BIT = 0;
  localparam int CTRL_DMA_EN_BIT = 1;
  localparam int CTRL_DMA_RESET_BIT = 2;
  localparam int CTRL_PACKED_BIT = 3;
  localparam int BURST_FIELD_W = 4;
  localparam int FRAME_WORDS_W = 24;
  localparam int IRQ_W = 3;
  localparam int IRQ_UNDERFLOW_BIT = 0;
  localparam int IRQ_FRAME_DONE_BIT = 1;
  localparam int IRQ_BOUNDARY_BIT = 2;

  // ************************************************************
  // Reset values and fixed counts
  // ************************************************************
  localparam logic [BURST_FIELD_W-1:0] BURST_FIELD_RST = 4'hf;
  localparam logic [31:0] FRAME_BASE_RST = 32'h0000_0000;
  localparam logic [FRAME_WORDS_W-1:0] FRAME_WORDS_RST = 24'h00_0000;
  localparam logic [8:0] WORDS_PER_KBYTE = 9'h100;
  localparam logic [2:0] BYTES_PER_PIXEL = 3'h3;
  localparam logic [2:0] BYTES_PACKED_WORD = 3'h4;

  // ************************************************************
  // Carriers and fetch states
  // ************************************************************
  typedef struct packed {
    logic req;
    logic [31:0] addr;
    logic [4:0] words;
  } lfbd_mreq_s;

  typedef struct packed {
    logic valid;
    logic [31:0] data;
  } lfbd_mresp_s;

  typedef struct packed {
    logic valid;
    logic [23:0] rgb;
  } lfbd_pix_s;

  typedef enum logic [1:0] {
    FETCH_IDLE,
    FETCH_REQ,
    FETCH_DATA
  } lfbd_fetch_e;

endpackage

// >>> testbench/lfbd_fetch_properties.sv
// Port checker of the frame fetch engine, bound to every instance.
// Assumes one clock domain and an active-low asynchronous reset.
`timescale 1ns/1ps

module lfbd_fetch_properties (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // Watched ports.
  input wire logic hreadyout,
  input wire logic hresp,
  input wire lfbd_pkg::lfbd_mreq_s mem_req,
  input wire logic mem_ack,
  input wire logic pix_req,
  input wire lfbd_pkg::lfbd_pix_s pix_out
);
  // ********
  // Properties
  // ********
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // Burst shape, request hold, pixel cause and bus answer.
  AST_KB_LINE: assert property (mem_req.req |-> {1'b0, mem_req.addr[9:2]} + 9'(mem_req.words) <= 9'h100)
    else $error("Burst crosses 1 KB.");
  AST_WORD_ALIGN: assert property (mem_req.req |-> mem_req.addr[1:0] == 2'h0)
    else $error("Burst not word aligned.");
  AST_BURST_SIZE: assert property (mem_req.req |-> mem_req.words inside {[5'h1:5'h10]})
    else $error("Burst size out of range.");
  AST_REQ_HOLD: assert property (mem_req.req && !mem_ack |=> mem_req.req && $stable(mem_req.addr))
    else $error("Request changed before ack.");
  AST_ONE_BURST: assert property (mem_req.req && mem_ack |=> !mem_req.req)
    else $error("Request overlaps a burst.");
  AST_PIX_CAUSE: assert property (pix_out.valid |-> $past(pix_req))
    else $error("Pixel without demand.");
  AST_OKAY: assert property (hresp == 1'b0)
    else $error("Bus error response.");
  AST_NO_WAIT: assert property (hreadyout == 1'b1)
    else $error("Wait state inserted.");
endmodule

bind lfbd_fetch lfbd_fetch_properties u_props (.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout),
  .hresp(hresp), .mem_req(mem_req), .mem_ack(mem_ack), .pix_req(pix_req), .pix_out(pix_out));

// >>> testbench/lfbd_mem_model.sv
// Memory model for the fetch engine: the word at byte address A holds A.
// Assumes one burst at a time; slow adds ack delay and beat gaps.
`timescale 1ns/1ps

module lfbd_mem_model (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // Request side and pacing.
  input wire lfbd_pkg::lfbd_mreq_s mem_req,
  input wire logic slow,
  output logic mem_ack,
  output lfbd_pkg::lfbd_mresp_s mem_rsp,
  output logic bad
);
  // ********
  // Burst answer
  // ********
  logic [31:0] a;
  logic [4:0] n;
  logic [1:0] w;

  // Idle data toggles every cycle so a stale word is never mistaken for a beat.
  // flags bursts crossing 1 KB
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mem_ack <= 1'b0;
      mem_rsp <= '0;
      a <= 32'h0;
      n <= 5'h0;
      w <= 2'h0;
      bad <= 1'b0;
    end else begin
      mem_ack <= 1'b0;
      w <= w + 2'h1;
      if (mem_req.req && !mem_ack && n == 5'h0 && (!slow || w == 2'h3)) begin
        mem_ack <= 1'b1;
        a <= mem_req.addr;
        n <= mem_req.words;
        if ({1'b0, mem_req.addr[9:2]} + 9'(mem_req.words) > 9'h100) bad <= 1'b1;
      end
      if (n != 5'h0 && (!slow || w[0])) begin
        mem_rsp <= {1'b1, a};
        a <= a + 32'h4;
        n <= n - 5'h1;
      end else begin
        mem_rsp <= {1'b0, ~mem_rsp.data};
      end
    end
  end
endmodule

// >>> testbench/lfbd_fetch_tb.sv
// Bench of the fetch engine: register tasks, recovery sequence, pixel checks.
// Assumes the memory model stores each word's own address.
`timescale 1ns/1ps

`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_total++; \
  $display("ERROR t=%0t got %h exp %h", $time, g, e); end end

module lfbd_fetch_tb;
  // ********
  // Signals and instances
  // ********
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, pix_req = 1'b0, slow = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, q, ctrl = 32'h0, hrdata;
  logic [1:0] htrans = 2'h0;
  logic hready, hreadyout, hresp, irq, bad, mem_ack;
  logic [4:0] last_words = 5'h0;
  lfbd_pkg::lfbd_mreq_s mem_req;
  lfbd_pkg::lfbd_mresp_s mem_rsp;
  lfbd_pkg::lfbd_pix_s pix_out;
  int err_total = 0;
  int checks = 0;

  // Clock at 40 MHz, single slave drives the bus ready.
  always #12.5 hclk = ~hclk;
  assign hready = hreadyout;
  // Size of the latest accepted burst.
  always @(posedge hclk) if (mem_req.req && mem_ack) last_words <= mem_req.words;

  lfbd_fetch #(.FIFO_DEPTH(32)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .mem_req(mem_req), .mem_ack(mem_ack),
    .mem_rsp(mem_rsp), .pix_req(pix_req), .pix_out(pix_out), .irq(irq));
  lfbd_mem_model mem (.hclk(hclk), .hresetn(hresetn), .mem_req(mem_req), .slow(slow),
    .mem_ack(mem_ack), .mem_rsp(mem_rsp), .bad(bad));

  // Verdict and end of run.
  task automatic results;
    $display("Mismatches %0d of %0d comparisons", err_total, checks);
    if (err_total == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // One AHB-Lite single transfer; read data lands in q.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hready !== 1'b1 && ++n < 50);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1 && ++n < 50);
    q = hrdata;
    if (w && a == lfbd_pkg::OFS_CTRL) ctrl = d;
    if (n >= 50) begin err_total++; results(); end
  endtask

  // Poll status: need 0 waits for idle, else for that many FIFO words.
  task automatic wait_status(input int need);
    int n;
    for (n = 0; n < 200; n++) begin
      bus(1'b0, lfbd_pkg::OFS_STATUS, 32'h0);
      if (need == 0 ? q[0] === 1'b0 : q[23:16] >= need) break;
    end
    if (n >= 200) begin err_total++; results(); end
  endtask

  // Byte of the model's memory, little-endian inside each word.
  function automatic logic [7:0] mem_byte(input logic [31:0] b);
    logic [31:0] w;
    w = {b[31:2], 2'h0};
    return w[8 * b[1:0] +: 8];
  endfunction

  // Demand cnt pixels from the start of a frame and compare each one.
  task automatic pixels(input logic [31:0] b, input int cnt, input logic pk);
    logic [31:0] e;
    int k, n;
    wait_status(8);
    for (k = 0; k < cnt; k++) begin
      e = pk ? {8'h0, mem_byte(b + 3 * k + 2), mem_byte(b + 3 * k + 1), mem_byte(b + 3 * k)} : b + 4 * k;
      @(posedge hclk);
      pix_req <= 1'b1;
      @(posedge hclk);
      pix_req <= 1'b0;
      n = 0;
      do @(posedge hclk); while (pix_out.valid !== 1'b1 && ++n < 8);
      if (n >= 8) begin err_total++; results(); end
      `CHK(pix_out.rgb, e[23:0])
    end
  endtask

  // Full recovery: power off, disable, wait idle, program, reset, power on, enable.
  task automatic restart(input logic [31:0] b, input logic [31:0] nw, input logic [3:0] bf, input logic pk);
    bus(1'b1, lfbd_pkg::OFS_CTRL, ctrl & 32'ha);
    bus(1'b1, lfbd_pkg::OFS_CTRL, 32'h0);
    wait_status(0);
    `CHK(q, 32'h0)
    bus(1'b1, lfbd_pkg::OFS_FRAME_CONFIG, {28'h0, bf});
    bus(1'b1, lfbd_pkg::OFS_FRAME_BASE, b);
    bus(1'b1, lfbd_pkg::OFS_FRAME_WORDS, nw);
    bus(1'b1, lfbd_pkg::OFS_CTRL, 32'h4);
    bus(1'b1, lfbd_pkg::OFS_CTRL, {28'h0, pk, 3'h1});
    bus(1'b1, lfbd_pkg::OFS_CTRL, {28'h0, pk, 3'h3});
  endtask

  // Main sequence: reset values, interrupt, then five frame set-ups.
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, lfbd_pkg::OFS_FRAME_CONFIG, 32'h0);
    `CHK(q, 32'hf)
    bus(1'b0, 8'h40, 32'h0);
    `CHK(q, 32'h0)
    bus(1'b1, lfbd_pkg::OFS_CTRL, 32'h1);
    @(posedge hclk);
    pix_req <= 1'b1;
    @(posedge hclk);
    pix_req <= 1'b0;
    bus(1'b1, lfbd_pkg::OFS_IRQ_ENABLE, 32'h1);
    bus(1'b0, lfbd_pkg::OFS_IRQ_STATUS, 32'h0);
    `CHK(q, 32'h1)
    `CHK(irq, 1'b1)
    bus(1'b1, lfbd_pkg::OFS_IRQ_ENABLE, 32'h0);
    bus(1'b0, lfbd_pkg::OFS_IRQ_STATUS, 32'h0);
    `CHK(irq, 1'b0)
    bus(1'b1, lfbd_pkg::OFS_IRQ_CLEAR, 32'h1);
    bus(1'b0, lfbd_pkg::OFS_IRQ_STATUS, 32'h0);
    `CHK(q, 32'h0)
    restart(32'h3f0, 32'h8, 4'h3, 1'b0);
    pixels(32'h3f0, 5, 1'b0);
    `CHK(last_words, 5'h4)
    restart(32'h3f0, 32'h8, 4'h3, 1'b0);
    pixels(32'h3f0, 8, 1'b0);
    slow <= 1'b1;
    restart(32'h30, 32'hc, 4'h3, 1'b1);
    pixels(32'h30, 8, 1'b1);
    `CHK(last_words, 5'h4)
    restart(32'hc0, 32'h10, 4'hf, 1'b1);
    pixels(32'hc0, 8, 1'b1);
    `CHK(last_words, 5'h10)
    bus(1'b0, lfbd_pkg::OFS_IRQ_STATUS, 32'h0);
    `CHK(q, 32'h2)
    bus(1'b1, lfbd_pkg::OFS_IRQ_CLEAR, 32'h7);
    // A base two words short of the 1-Kbyte line must be clipped, not crossed.
    restart(32'h3f8, 32'h8, 4'h3, 1'b0);
    pixels(32'h3f8, 8, 1'b0);
    bus(1'b0, lfbd_pkg::OFS_IRQ_STATUS, 32'h0);
    `CHK(q[2], 1'b1)
    `CHK(bad, 1'b0)
    results();
  end
endmodule
